/* core/vccr_pkg.sv */
// Constants and carrier types for the VCO calibration control and readback registers
package vccr_pkg;

   // ---------------------------------------------------------------
   // Serial frame layout: one read/write flag, seven address bits, sixteen data bits
   // ---------------------------------------------------------------
   localparam logic [4:0] HDR_BITS   = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int         ADDR_W     = 7;
   localparam int         DATA_W     = 16;
   localparam int         RW_POS     = 6;         // Flag position in the shifter at header end
   localparam int         PIN_SCK    = 0;
   localparam int         PIN_CS_N   = 1;
   localparam int         PIN_SDI    = 2;

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_LOCK_CFG  = 7'h3d;
   localparam logic [6:0] ADDR_RES_A     = 7'h3e;
   localparam logic [6:0] ADDR_FAST_CAL  = 7'h40;
   localparam logic [6:0] ADDR_LOCK_CORE = 7'h44;
   localparam logic [6:0] ADDR_CAP_RB    = 7'h45;
   localparam logic [6:0] ADDR_BIAS_RB   = 7'h46;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int FAST_AMP_BIT   = 9;
   localparam int FAST_FREQ_BIT  = 8;
   localparam int AMP_STEP_LSB   = 5;
   localparam int FREQ_STEP_LSB  = 0;
   localparam int LOCK_KIND_BIT  = 0;
   localparam int TUNE_LOCK_LSB  = 9;
   localparam int CORE_LSB       = 5;

   // ---------------------------------------------------------------
   // Reset values; reserved bits come up as zero
   // ---------------------------------------------------------------
   localparam logic [2:0]  AMP_STEP_RST  = 3'h3;
   localparam logic [3:0]  FREQ_STEP_RST = 4'hf;
   localparam logic [15:0] FAST_CAL_RST  = 16'h006f;
   localparam logic [15:0] RES_A_RST     = 16'h0000;
   localparam logic [15:0] LOCK_CFG_RST  = 16'h0001;
   localparam logic [1:0]  TUNE_LOCKED   = 2'h2;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       cal_ok;            // Calibration finished successfully
      logic [1:0] tune_lock_status;  // Tune-voltage window result
      logic [2:0] selected_core;     // Core picked by calibration
      logic [7:0] cap_setting;       // Capacitor code picked
      logic [8:0] bias_dac_setting;  // Bias DAC code picked
   } vccr_cal_result_t;

   typedef struct packed {
      logic       fast_amp_cal_enable;
      logic       fast_freq_cal_enable;
      logic [2:0] amp_cal_step;
      logic [3:0] freq_cal_step;
      logic       lock_detect_kind;
   } vccr_cal_ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HEAD = 2'b01,
      ST_DATA = 2'b10,
      ST_DONE = 2'b11
   } vccr_state_t;

endpackage

/* core/vccr_regs.sv */
// Serial register port with VCO calibration control and readback registers
//
// Summary of operation
// R1 - Control bit 9 enables fast amplitude calibration; resets to 0.
// R2 - Control bit 8 enables fast frequency calibration; resets to 0.
// R3 - Control bits 7:5 give amplitude calibration step; resets to 3.
// R4 - Control bits 3:0 give frequency calibration step; resets to 15.
// R5 - Readback bits 10:9 report tune-voltage lock: 2 locked, others not.
// R6 - Readback bits 7:5 report the core calibration selected.
// R7 - Readback bits 7:0 return the chosen capacitor setting.
// R8 - Readback bits 8:0 return the chosen bias DAC setting.
// R9 - Software writes reserved fields with their default values.
// R10 - Lock kind bit picks completion status or tune-voltage check as lock.
// R11 - Writes to readback registers are ignored; fields hold latest result.
`timescale 1ns/1ps
`default_nettype none
module vccr_regs (
   // Clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_reset_n,
   // Serial register port pins
   input  wire logic                      i_sck,
   input  wire logic                      i_cs_n,
   input  wire logic                      i_sdi,
   output var  logic                      o_sdo,
   output var  logic                      o_sdo_oe,
   // Calibration engine
   input  wire logic                      i_cal_done,
   input  wire vccr_pkg::vccr_cal_result_t i_cal_result,
   output var  vccr_pkg::vccr_cal_ctrl_t   o_cal_ctrl,
   output var  logic                      o_lock_detect
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic       sck_d;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_act;
   logic       sdi;

   // Two stages before any logic; the third stage only feeds edge detection
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_s1 <= 3'h2;
         pin_s2 <= 3'h2;
         sck_d  <= 1'b0;
      end else begin
         pin_s1 <= {i_sdi, i_cs_n, i_sck};
         pin_s2 <= pin_s1;
         sck_d  <= pin_s2[vccr_pkg::PIN_SCK];
      end
   end

   // Edges and levels seen by the frame logic
   assign sck_rise = pin_s2[vccr_pkg::PIN_SCK] & ~sck_d;
   assign sck_fall = ~pin_s2[vccr_pkg::PIN_SCK] & sck_d;
   assign cs_act   = ~pin_s2[vccr_pkg::PIN_CS_N];
   assign sdi      = pin_s2[vccr_pkg::PIN_SDI];

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [15:0] res_a;
   logic [15:0] fast_cal;
   logic [15:0] lock_cfg;
   logic [15:0] next_res_a;
   logic [15:0] next_fast_cal;
   logic [15:0] next_lock_cfg;
   vccr_pkg::vccr_cal_result_t rb;
   vccr_pkg::vccr_cal_result_t next_rb;
   logic       lock_det;
   logic       next_lock_det;

   // Read decode, used only by the frame loader at header end
   function automatic logic [15:0] read_word(input logic [6:0] a,
                                             input logic [15:0] ra,
                                             input logic [15:0] fc,
                                             input logic [15:0] lc,
                                             input vccr_pkg::vccr_cal_result_t r);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         vccr_pkg::ADDR_LOCK_CFG:  w = lc;
         vccr_pkg::ADDR_RES_A:     w = ra;
         vccr_pkg::ADDR_FAST_CAL:  w = fc;
         vccr_pkg::ADDR_LOCK_CORE: begin
            w[vccr_pkg::TUNE_LOCK_LSB +: 2] = r.tune_lock_status; // [R5]
            w[vccr_pkg::CORE_LSB +: 3]      = r.selected_core;    // [R6]
         end
         vccr_pkg::ADDR_CAP_RB:    w[7:0] = r.cap_setting;        // [R7]
         vccr_pkg::ADDR_BIAS_RB:   w[8:0] = r.bias_dac_setting;   // [R8]
         default:                  w = 16'h0000;                  // Unmapped reads zero
      endcase
      return w;
   endfunction

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   vccr_pkg::vccr_state_t state;
   vccr_pkg::vccr_state_t next_state;
   logic [4:0]  bit_cnt;
   logic [4:0]  next_bit_cnt;
   logic [15:0] shifter;
   logic [15:0] next_shifter;
   logic        rd_frame;
   logic        next_rd_frame;
   logic [6:0]  addr;
   logic [6:0]  next_addr;
   logic [15:0] tx;
   logic [15:0] next_tx;
   logic        next_sdo;
   logic        next_sdo_oe;
   logic        wr_commit;
   logic [15:0] wr_data;

   // Header bits arrive MSB first; write commits on the last rising edge
   always_comb begin
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_shifter  = shifter;
      next_rd_frame = rd_frame;
      next_addr     = addr;
      next_tx       = tx;
      next_sdo      = o_sdo;
      next_sdo_oe   = o_sdo_oe;
      wr_commit     = 1'b0;
      wr_data       = {shifter[14:0], sdi};
      if (!cs_act) begin
         next_state   = vccr_pkg::ST_IDLE;
         next_bit_cnt = 5'h00;
         next_sdo_oe  = 1'b0;
         next_sdo     = 1'b0;
      end else begin
         case (state)
            vccr_pkg::ST_IDLE: begin
               next_state = vccr_pkg::ST_HEAD;
            end
            vccr_pkg::ST_HEAD: begin
               if (sck_rise) begin
                  next_shifter = {shifter[14:0], sdi};
                  next_bit_cnt = 5'(bit_cnt + 5'h01);
                  if (next_bit_cnt == vccr_pkg::HDR_BITS) begin
                     next_rd_frame = shifter[vccr_pkg::RW_POS];
                     next_addr     = {shifter[5:0], sdi};
                     next_tx       = read_word(next_addr, res_a, fast_cal, lock_cfg, rb);
                     next_sdo_oe   = shifter[vccr_pkg::RW_POS];
                     next_state    = vccr_pkg::ST_DATA;
                  end
               end
            end
            vccr_pkg::ST_DATA: begin
               if (sck_rise) begin
                  next_shifter = {shifter[14:0], sdi};
                  next_bit_cnt = 5'(bit_cnt + 5'h01);
                  if (next_bit_cnt == vccr_pkg::FRAME_BITS) begin
                     wr_commit  = ~rd_frame;
                     next_state = vccr_pkg::ST_DONE;
                  end
               end else if (sck_fall && rd_frame) begin
                  next_sdo = tx[15];               // Master samples on the next rise
                  next_tx  = {tx[14:0], 1'b0};
               end
            end
            vccr_pkg::ST_DONE: begin
               // Extra clocks past the frame are ignored until select drops
               if (sck_fall && rd_frame) begin
                  next_sdo = 1'b0;
               end
            end
            default: begin
               next_state = vccr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Frame engine registers
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state    <= vccr_pkg::ST_IDLE;
         bit_cnt  <= 5'h00;
         shifter  <= 16'h0000;
         rd_frame <= 1'b0;
         addr     <= 7'h00;
         tx       <= 16'h0000;
         o_sdo    <= 1'b0;
         o_sdo_oe <= 1'b0;
      end else begin
         state    <= next_state;
         bit_cnt  <= next_bit_cnt;
         shifter  <= next_shifter;
         rd_frame <= next_rd_frame;
         addr     <= next_addr;
         tx       <= next_tx;
         o_sdo    <= next_sdo;
         o_sdo_oe <= next_sdo_oe;
      end
   end

   // ---------------------------------------------------------------
   // Writable registers
   // ---------------------------------------------------------------

   // Reserved bits are stored as written, so software keeps the defaults itself
   always_comb begin
      next_res_a    = res_a;
      next_fast_cal = fast_cal;
      next_lock_cfg = lock_cfg;
      if (wr_commit) begin
         case (addr)
            vccr_pkg::ADDR_RES_A:    next_res_a    = wr_data;          // [R9]
            vccr_pkg::ADDR_FAST_CAL: next_fast_cal = wr_data;          // [R1] [R2] [R3] [R4]
            vccr_pkg::ADDR_LOCK_CFG: next_lock_cfg = wr_data;          // [R10]
            default:                 next_res_a    = res_a;            // Readback writes drop [R11]
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         res_a    <= vccr_pkg::RES_A_RST;
         fast_cal <= vccr_pkg::FAST_CAL_RST;
         lock_cfg <= vccr_pkg::LOCK_CFG_RST;
      end else begin
         res_a    <= next_res_a;
         fast_cal <= next_fast_cal;
         lock_cfg <= next_lock_cfg;
      end
   end

   // Control fields toward the calibration engine, straight from the flops
   assign o_cal_ctrl.fast_amp_cal_enable  = fast_cal[vccr_pkg::FAST_AMP_BIT];       // [R1]
   assign o_cal_ctrl.fast_freq_cal_enable = fast_cal[vccr_pkg::FAST_FREQ_BIT];      // [R2]
   assign o_cal_ctrl.amp_cal_step         = fast_cal[vccr_pkg::AMP_STEP_LSB +: 3];  // [R3]
   assign o_cal_ctrl.freq_cal_step        = fast_cal[vccr_pkg::FREQ_STEP_LSB +: 4]; // [R4]
   assign o_cal_ctrl.lock_detect_kind     = lock_cfg[vccr_pkg::LOCK_KIND_BIT];      // [R10]

   // ---------------------------------------------------------------
   // Calibration readback and lock indication
   // ---------------------------------------------------------------

   // Results are captured only at calibration end, so a read never sees a half update
   always_comb begin
      next_rb = rb;
      if (i_cal_done) begin
         next_rb = i_cal_result;                                       // [R5] [R6] [R7] [R8] [R11]
      end
      if (o_cal_ctrl.lock_detect_kind) begin
         next_lock_det = (rb.tune_lock_status == vccr_pkg::TUNE_LOCKED); // [R10]
      end else begin
         next_lock_det = rb.cal_ok;                                    // [R10]
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rb       <= '0;
         lock_det <= 1'b0;
      end else begin
         rb       <= next_rb;
         lock_det <= next_lock_det;
      end
   end

   assign o_lock_detect = lock_det;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   fast_amp_write_a: assert property (wr_commit && addr == vccr_pkg::ADDR_FAST_CAL |=> // [R1]
      o_cal_ctrl.fast_amp_cal_enable == $past(wr_data[vccr_pkg::FAST_AMP_BIT]))
      else $error("fast amplitude enable did not follow write");
   fast_freq_write_a: assert property (wr_commit && addr == vccr_pkg::ADDR_FAST_CAL |=> // [R2]
      o_cal_ctrl.fast_freq_cal_enable == $past(wr_data[vccr_pkg::FAST_FREQ_BIT]))
      else $error("fast frequency enable did not follow write");
   amp_step_hold_a: assert property (!(wr_commit && addr == vccr_pkg::ADDR_FAST_CAL) |=> // [R3]
      $stable(o_cal_ctrl.amp_cal_step))
      else $error("amplitude step changed without a write");
   freq_step_write_a: assert property (wr_commit && addr == vccr_pkg::ADDR_FAST_CAL |=> // [R4]
      o_cal_ctrl.freq_cal_step == $past(wr_data[3:0]))
      else $error("frequency step did not follow write");
   lock_capture_a: assert property (i_cal_done |=>                                      // [R5]
      rb.tune_lock_status == $past(i_cal_result.tune_lock_status))
      else $error("lock readback not captured");
   core_capture_a: assert property (i_cal_done |=>                                      // [R6]
      rb.selected_core == $past(i_cal_result.selected_core))
      else $error("core readback not captured");
   cap_capture_a: assert property (i_cal_done |=>                                       // [R7]
      rb.cap_setting == $past(i_cal_result.cap_setting))
      else $error("capacitor readback not captured");
   bias_capture_a: assert property (i_cal_done |=>                                      // [R8]
      rb.bias_dac_setting == $past(i_cal_result.bias_dac_setting))
      else $error("bias readback not captured");
   lock_kind_sel_a: assert property (o_cal_ctrl.lock_detect_kind && rb.cal_ok            // [R10]
      && rb.tune_lock_status != vccr_pkg::TUNE_LOCKED ##1 $stable(rb)
      && o_cal_ctrl.lock_detect_kind |-> !o_lock_detect)
      else $error("lock output ignored tune-voltage selection");
   ro_write_drop_a: assert property (wr_commit && !i_cal_done                           // [R11]
      && addr >= vccr_pkg::ADDR_LOCK_CORE |=> $stable(rb))
      else $error("readback changed on a write");

   write_fast_c: cover property (wr_commit && addr == vccr_pkg::ADDR_FAST_CAL);
   read_frame_c: cover property (state == vccr_pkg::ST_DATA && rd_frame ##[1:200]
      state == vccr_pkg::ST_DONE);
   cal_done_c:   cover property (i_cal_done ##1 o_lock_detect);

endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the VCO calibration control and readback registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ---------------------------------------------------------------
   // Stimulus, observed outputs and counters
   // ---------------------------------------------------------------
   logic                       i_clk_sys = 1'b0;
   logic                       i_reset_n;
   logic                       i_sck;
   logic                       i_cs_n;
   logic                       i_sdi;
   logic                       i_cal_done;
   vccr_pkg::vccr_cal_result_t i_cal_result;
   logic                       o_sdo;
   logic                       o_sdo_oe;
   logic                       o_lock_detect;
   vccr_pkg::vccr_cal_ctrl_t   o_cal_ctrl;
   int                         error_cnt = 0;
   int                         n_compared = 0;
   logic [15:0]                rd;
   logic [15:0]                wtab [6] = '{16'h0300, 16'h0200, 16'h0100, 16'h00ef, 16'h0000,
                                            16'h03ef};
   vccr_pkg::vccr_cal_result_t r;

   // Free-running 100 MHz system clock
   always #5 i_clk_sys = ~i_clk_sys;

   vccr_regs uut (
      .i_clk_sys     (i_clk_sys),
      .i_reset_n     (i_reset_n),
      .i_sck         (i_sck),
      .i_cs_n        (i_cs_n),
      .i_sdi         (i_sdi),
      .o_sdo         (o_sdo),
      .o_sdo_oe      (o_sdo_oe),
      .i_cal_done    (i_cal_done),
      .i_cal_result  (i_cal_result),
      .o_cal_ctrl    (o_cal_ctrl),
      .o_lock_detect (o_lock_detect)
   );

   // ---------------------------------------------------------------
   // Helpers: timing, comparisons, serial frames
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask

   task automatic finish_test();
      $display("TB: %0d compared, %0d mismatches", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got,
                           input logic [15:0] mask);
      n_compared++;
      if ((got & mask) !== (exp & mask)) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp & mask, got & mask);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   // One frame, MSB first; sck half periods of 6 clocks keep the sync chain
   // well clear of its minimum. A short nbits aborts the frame mid-way.
   task automatic xfer(input logic rw, input logic [6:0] addr, input logic [15:0] wd,
                       input int nbits, output logic [15:0] rdat);
      logic [23:0] frame;
      frame = {rw, addr, wd};
      rdat = 16'h0000;
      i_cs_n = 1'b0;
      cyc(5);
      for (int k = 0; k < nbits; k++) begin
         i_sdi = (k < 24) ? frame[23-k] : 1'b1; // Surplus clocks carry ones
         cyc(6);
         if (rw && k >= 8) begin
            rdat[23-k] = o_sdo;
         end
         if (rw && k == 8) begin
            chk_bit("read drive enable", 1'b1, o_sdo_oe);
         end
         i_sck = 1'b1;
         cyc(6);
         i_sck = 1'b0;
      end
      cyc(6);
      i_cs_n = 1'b1;
      cyc(8);
      chk_bit("idle drive enable", 1'b0, o_sdo_oe);
      chk_bit("idle data line", 1'b0, o_sdo);
   endtask

   task automatic wr(input logic [6:0] addr, input logic [15:0] wd);
      logic [15:0] dummy;
      xfer(1'b0, addr, wd, 24, dummy);
   endtask

   task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp,
                         input logic [15:0] mask, input string what);
      xfer(1'b1, addr, 16'h0000, 24, rd);
      chk_word(what, exp, rd, mask);
   endtask

   // Calibration engine pulse; result lands next cycle, lock one later
   task automatic cal(input vccr_pkg::vccr_cal_result_t res);
      i_cal_result = res;
      i_cal_done = 1'b1;
      cyc(1);
      i_cal_done = 1'b0;
      cyc(3);
   endtask

   function automatic logic [15:0] exp_ctrl(input logic [15:0] w, input logic kind);
      return {6'h00, w[9], w[8], w[7:5], w[3:0], kind};
   endfunction

   task automatic done(input string n);
      $display("TB: test %s finished", n);
   endtask

   // Hang guard, well beyond the roughly 16.5k cycles the tests need
   initial begin
      cyc(60000);
      error_cnt++;
      finish_test();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      i_reset_n = 1'b0;
      i_sck = 1'b0;
      i_cs_n = 1'b1;
      i_sdi = 1'b0;
      i_cal_done = 1'b0;
      i_cal_result = '0;
      cyc(16);
      i_reset_n = 1'b1;
      cyc(4);
      // Reset values at the pins and through the port
      chk_word("reset ctrl", exp_ctrl(16'h006f, 1'b1), {6'h00, o_cal_ctrl},
               16'h03ff);
      chk_bit("reset lock", 1'b0, o_lock_detect);
      rd_chk(vccr_pkg::ADDR_FAST_CAL, 16'h006f, 16'h03ef, "reset fast cal");
      rd_chk(vccr_pkg::ADDR_LOCK_CFG, 16'h0001, 16'h0001, "reset lock kind");
      rd_chk(vccr_pkg::ADDR_LOCK_CORE, 16'h0000, 16'h06e0, "reset lock core");
      rd_chk(vccr_pkg::ADDR_CAP_RB, 16'h0000, 16'h00ff, "reset cap");
      rd_chk(vccr_pkg::ADDR_BIAS_RB, 16'h0000, 16'h01ff, "reset bias");
      done("reset values");
      // Enables and step fields, boundaries included; reserved bits kept at 0
      foreach (wtab[i]) begin
         wr(vccr_pkg::ADDR_FAST_CAL, wtab[i]);
         chk_word("ctrl", exp_ctrl(wtab[i], 1'b1), {6'h00, o_cal_ctrl}, 16'h03ff);
         rd_chk(vccr_pkg::ADDR_FAST_CAL, wtab[i], 16'h03ef, "fast cal");
      end
      // Aborted frame must leave the last value in place
      xfer(1'b0, vccr_pkg::ADDR_FAST_CAL, 16'h0000, 12, rd);
      rd_chk(vccr_pkg::ADDR_FAST_CAL, 16'h03ef, 16'h03ef, "abort fast cal");
      // Clocks past the 24th are ignored; the write itself still lands
      xfer(1'b0, vccr_pkg::ADDR_FAST_CAL, 16'h0100, 26, rd);
      rd_chk(vccr_pkg::ADDR_FAST_CAL, 16'h0100, 16'h03ef, "long fast cal");
      done("control fields");
      // Core numbers 1 to 7 and every lock code through the readbacks
      for (int c = 1; c < 8; c++) begin
         r = {1'b1, 2'(c % 4), 3'(c), 8'(c * 36), 9'(c * 73)};
         cal(r);
         chk_bit("lock vtune", r.tune_lock_status == 2'h2, o_lock_detect);
         rd_chk(vccr_pkg::ADDR_LOCK_CORE, {5'h00, r.tune_lock_status, 1'b0,
                r.selected_core, 5'h00}, 16'h06e0, "lock core");
         rd_chk(vccr_pkg::ADDR_CAP_RB, {8'h00, r.cap_setting}, 16'h00ff, "cap");
         rd_chk(vccr_pkg::ADDR_BIAS_RB, {7'h00, r.bias_dac_setting}, 16'h01ff, "bias");
      end
      done("calibration readback");
      // Readbacks ignore writes; unmapped place reads as zero
      wr(vccr_pkg::ADDR_LOCK_CORE, 16'hffff);
      wr(vccr_pkg::ADDR_CAP_RB, 16'h0000);
      wr(vccr_pkg::ADDR_BIAS_RB, 16'h0000);
      wr(7'h41, 16'hffff);
      rd_chk(vccr_pkg::ADDR_LOCK_CORE, 16'h06e0, 16'h06e0, "ro lock core");
      rd_chk(vccr_pkg::ADDR_CAP_RB, 16'h00fc, 16'h00ff, "ro cap");
      rd_chk(vccr_pkg::ADDR_BIAS_RB, 16'h01ff, 16'h01ff, "ro bias");
      rd_chk(7'h41, 16'h0000, 16'hffff, "unmapped");
      done("read-only places");
      // Lock kind: tune window versus completion status
      cal({1'b1, 2'h1, 3'h2, 8'h5a, 9'h0a5});
      chk_bit("kind 1 invalid", 1'b0, o_lock_detect);
      wr(vccr_pkg::ADDR_LOCK_CFG, 16'h0000);
      chk_bit("kind out", 1'b0, o_cal_ctrl.lock_detect_kind);
      chk_bit("kind 0 cal ok", 1'b1, o_lock_detect);
      cal({1'b0, 2'h2, 3'h2, 8'h5a, 9'h0a5});
      chk_bit("kind 0 cal fail", 1'b0, o_lock_detect);
      wr(vccr_pkg::ADDR_LOCK_CFG, 16'h0001);
      chk_bit("kind 1 locked", 1'b1, o_lock_detect);
      done("lock kind");
      // Mid-run reset returns control fields, lock and readbacks to defaults
      i_reset_n = 1'b0;
      cyc(3);
      i_reset_n = 1'b1;
      cyc(4);
      chk_word("rerun ctrl", exp_ctrl(16'h006f, 1'b1), {6'h00, o_cal_ctrl},
               16'h03ff);
      chk_bit("rerun lock", 1'b0, o_lock_detect);
      rd_chk(vccr_pkg::ADDR_FAST_CAL, 16'h006f, 16'h03ef, "rerun fast cal");
      rd_chk(vccr_pkg::ADDR_BIAS_RB, 16'h0000, 16'h01ff, "rerun bias");
      done("mid-run reset");
      finish_test();
   end
endmodule
`default_nettype wire
